/* design/stm_timer.sv */
// Standard 16-bit timer: compare match, timer, PWM, single pulse and
// capture modes, with an APB register slave.
// Assumes synchronous pin inputs and a one-cycle timer tick enable.

`timescale 1ns/1ps

module stm_timer (
    // Clock, reset and clock enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer pins
    input  wire logic        timer_tick,
    input  wire logic        external_trigger_pin,
    input  wire logic        capture_input_pin,
    output logic             timer_out,
    output logic             timer_out_en,
    // Flags
    output logic             match_a_flag,
    output logic             match_p_flag
);
    import stm_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    // All state sits in one packed word, so a single register holds it.
    typedef struct packed {
        logic [9:0]  ctrl;
        logic        run;
        logic        run_q;
        logic [15:0] cmpa;
        logic [7:0]  perd;
        logic [15:0] cnt;
        logic        fa;
        logic        fp;
        logic        lvl;
        logic        trig_q;
        logic        cap_q;
        logic        pin;
        logic        pin_en;
        logic [31:0] rdata;
    } stm_state_t;

    stm_state_t st_reg;
    stm_state_t st_next;

    // Decoded views of the state and this cycle's events.
    stm_mode_t   mode;
    logic [1:0]  pin_act;
    logic        oc;
    logic        pol;
    logic        dpx;
    logic        cclr;
    logic        start;
    logic        step;
    logic [16:0] cnt_inc;
    logic [16:0] p_len;
    logic [16:0] a_len;
    logic [16:0] duty;
    logic        a_end;
    logic        p_end;
    logic        pwm_on;
    logic        single;
    logic        acc;
    logic        wr;
    logic        addr_ok;

    // ************************************************************
    // Decoded control and match events
    // ************************************************************
    // Field views of the control word.
    assign mode    = stm_mode_t'(st_reg.ctrl[STM_MODE_LSB +: 2]);
    assign pin_act = st_reg.ctrl[STM_PIN_LSB +: 2];
    assign oc      = st_reg.ctrl[STM_OC_BIT];
    assign pol     = st_reg.ctrl[STM_POL_BIT];
    assign dpx     = st_reg.ctrl[STM_DPX_BIT];
    assign cclr    = st_reg.ctrl[STM_CCLR_BIT];
    assign single  = (mode == STM_MODE_PWM) && (pin_act == 2'b11);

    // A run rising edge restarts, so it takes the place of a count step.
    assign start   = st_reg.run & ~st_reg.run_q;
    assign step    = st_reg.run & ~start & timer_tick;
    // One bit wider, so the full 65536 count compares without wrapping.
    assign cnt_inc = {1'b0, st_reg.cnt} + 17'h00001;

    // P compares only the upper byte, so its length is a multiple of 256;
    // a zero value stands for the full 65536 count.
    assign p_len = (st_reg.perd == 8'h00) ? 17'h10000 :
                   (17'(st_reg.perd) << STM_PERD_SHIFT);
    assign a_len = {1'b0, st_reg.cmpa};

    // A match ends the cycle in which the counter would reach the value.
    assign a_end = step && (cnt_inc == a_len);
    assign p_end = step && (cnt_inc == p_len);

    // Duty and period pairing follows the swap bit.
    assign duty   = dpx ? p_len : a_len;
    // Comparing against duty alone gives full duty when duty >= period;
    // a duty of zero leaves the output inactive for the whole period.
    assign pwm_on = ({1'b0, st_reg.cnt} < duty);

    // ************************************************************
    // APB handshake
    // ************************************************************
    // Zero wait states; a low clock enable stretches the access phase.
    // The read-only counter offset accepts writes and ignores them.
    assign acc     = psel & penable;
    assign wr      = acc & pwrite & ce;
    assign addr_ok = (paddr == STM_CTRL_OFS) || (paddr == STM_CMPA_OFS) ||
                     (paddr == STM_PERD_OFS) || (paddr == STM_CNT_OFS) ||
                     (paddr == STM_FLAG_OFS);
    assign pready  = acc & ce;
    assign pslverr = acc & ce & ~addr_ok;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic clr;
        logic set_a;
        logic set_p;
        logic trig;
        logic cap_edge;
        logic run_clr;
        clr      = 1'b0;
        set_a    = 1'b0;
        set_p    = 1'b0;
        trig     = 1'b0;
        cap_edge = 1'b0;
        run_clr  = 1'b0;
        st_next  = st_reg;

        st_next.run_q  = st_reg.run;
        st_next.trig_q = external_trigger_pin;
        st_next.cap_q  = capture_input_pin;

        // Per-mode clear sources and flag events.
        unique case (mode)
            STM_MODE_CMP, STM_MODE_TMR: begin
                if (cclr) begin
                    clr   = a_end;
                    set_a = a_end;
                end else begin
                    // Zero P wraps at 65536, which is the overflow.
                    clr   = p_end;
                    set_a = a_end;
                    set_p = p_end;
                end
            end
            STM_MODE_PWM: begin
                if (single) begin
                    // Counter is never cleared by a match here.
                    run_clr = a_end;
                    set_a   = a_end;
                    // The pin idles low and its sample resets low: no false edge.
                    trig    = st_reg.ctrl[STM_TFALL_BIT] ?
                              (st_reg.trig_q & ~external_trigger_pin) :
                              (~st_reg.trig_q & external_trigger_pin);
                end else begin
                    // Clear select is ignored; P clears, or A when the swap bit is set.
                    clr   = dpx ? a_end : p_end;
                    set_a = a_end;
                    set_p = p_end;
                end
            end
            STM_MODE_CAP: begin
                clr   = p_end;
                set_p = p_end;
                // Pin action 11 selects no edge at all.
                unique case (pin_act)
                    2'b00: cap_edge = ~st_reg.cap_q & capture_input_pin;
                    2'b01: cap_edge = st_reg.cap_q & ~capture_input_pin;
                    2'b10: cap_edge = st_reg.cap_q ^ capture_input_pin;
                    2'b11: cap_edge = 1'b0;
                endcase
                cap_edge = cap_edge & st_reg.run;
                set_a    = cap_edge;
            end
        endcase

        // Counter: restart on run rise, step or clear on a tick.
        // A clear lands on zero at the tick itself, so the period is exact.
        if (start) begin
            st_next.cnt = STM_CNT_RST;
        end else if (step) begin
            st_next.cnt = clr ? STM_CNT_RST : cnt_inc[15:0];
        end

        // Compare output level; a run rise restores the initial level.
        // The level is kept unpolarised; invert is applied at the pin only.
        if (start) begin
            st_next.lvl = oc;
        end else if (a_end) begin
            unique case (pin_act)
                2'b00: st_next.lvl = st_reg.lvl;
                2'b01: st_next.lvl = 1'b0;
                2'b10: st_next.lvl = 1'b1;
                2'b11: st_next.lvl = ~st_reg.lvl;
            endcase
        end

        // Control writes and the counter run bit.
        // Run lives apart from the control word so the trigger can set it.
        if (wr && paddr == STM_CTRL_OFS) begin
            st_next.ctrl = pwdata[9:0];
            st_next.ctrl[STM_RUN_BIT] = 1'b0;
            st_next.run  = pwdata[STM_RUN_BIT];
        end
        if (run_clr) begin
            st_next.run = 1'b0;
        end
        // A trigger edge sets run and wins over any clear.
        if (trig) begin
            st_next.run = 1'b1;
        end

        // Compare registers; a capture wins over a software write.
        // Compare A doubles as the capture register in capture mode.
        if (wr && paddr == STM_CMPA_OFS) begin
            st_next.cmpa = pwdata[15:0];
        end
        if (cap_edge) begin
            st_next.cmpa = st_reg.cnt;
        end
        if (wr && paddr == STM_PERD_OFS) begin
            st_next.perd = pwdata[7:0];
        end

        // Sticky flags, write one to clear; a new event wins.
        // No interrupt line leaves the block; software polls these flags.
        if (wr && paddr == STM_FLAG_OFS) begin
            st_next.fa = st_reg.fa & ~pwdata[STM_FA_BIT];
            st_next.fp = st_reg.fp & ~pwdata[STM_FP_BIT];
        end
        if (set_a) begin
            st_next.fa = 1'b1;
        end
        if (set_p) begin
            st_next.fp = 1'b1;
        end

        // Output pin, registered one cycle behind the state it shows.
        // Only modes 00 and 10 drive the pin; the others release it.
        unique case (mode)
            STM_MODE_CMP: begin
                st_next.pin    = st_reg.lvl ^ pol;
                st_next.pin_en = 1'b1;
            end
            STM_MODE_PWM: begin
                st_next.pin_en = 1'b1;
                if (single) begin
                    st_next.pin = (st_reg.run ? oc : ~oc) ^ pol;
                end else if (pin_act == 2'b10) begin
                    st_next.pin = (pwm_on ? oc : ~oc) ^ pol;
                end else begin
                    // Forced level; the generator keeps running beneath.
                    st_next.pin = pin_act[0];
                end
            end
            STM_MODE_CAP, STM_MODE_TMR: begin
                st_next.pin    = 1'b0;
                st_next.pin_en = 1'b0;
            end
        endcase

        // Read data is sampled in the setup phase.
        // Unmapped offsets read zero; pslverr reports them in the access phase.
        if (psel && !penable) begin
            unique case (paddr)
                STM_CTRL_OFS: begin
                    st_next.rdata = 32'(st_reg.ctrl) |
                                    (32'(st_reg.run) << STM_RUN_BIT);
                end
                STM_CMPA_OFS: st_next.rdata = 32'(st_reg.cmpa);
                STM_PERD_OFS: st_next.rdata = 32'(st_reg.perd);
                STM_CNT_OFS:  st_next.rdata = 32'(st_reg.cnt);
                STM_FLAG_OFS: begin
                    st_next.rdata = (32'(st_reg.fa) << STM_FA_BIT) |
                                    (32'(st_reg.fp) << STM_FP_BIT);
                end
                default:      st_next.rdata = 32'h00000000;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // The clock enable freezes every field, the bus answer included.
    // Reset is asynchronous so the pin is quiet before the first clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg        <= '0;
            st_reg.ctrl   <= STM_CTRL_RST;
            st_reg.cmpa   <= STM_CMPA_RST;
            st_reg.perd   <= STM_PERD_RST;
            st_reg.cnt    <= STM_CNT_RST;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Pin, flag and read data outputs come straight from the state register, free of glitches; pready and pslverr are combinational.
    assign prdata       = st_reg.rdata;
    assign timer_out    = st_reg.pin;
    assign timer_out_en = st_reg.pin_en;
    assign match_a_flag = st_reg.fa;
    assign match_p_flag = st_reg.fp;

endmodule

/* design/stm_pkg.sv */
// Constants shared by the standard timer block: register offsets,
// control field positions, reset values and the operating mode encoding.
// Assumes a 32-bit APB bus with byte addresses and word-aligned registers.

package stm_pkg;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] STM_CTRL_OFS = 8'h00;
    localparam logic [7:0] STM_CMPA_OFS = 8'h04;
    localparam logic [7:0] STM_PERD_OFS = 8'h08;
    localparam logic [7:0] STM_CNT_OFS  = 8'h0c;
    localparam logic [7:0] STM_FLAG_OFS = 8'h10;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int STM_CCLR_BIT   = 0;
    localparam int STM_DPX_BIT    = 1;
    localparam int STM_POL_BIT    = 2;
    localparam int STM_OC_BIT     = 3;
    localparam int STM_PIN_LSB    = 4;
    localparam int STM_MODE_LSB   = 6;
    localparam int STM_RUN_BIT    = 8;
    localparam int STM_TFALL_BIT  = 9;
    localparam int STM_FA_BIT     = 0;
    localparam int STM_FP_BIT     = 1;
    localparam int STM_PERD_SHIFT = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [9:0]  STM_CTRL_RST = 10'h000;
    localparam logic [15:0] STM_CMPA_RST = 16'h0000;
    localparam logic [7:0]  STM_PERD_RST = 8'h00;
    localparam logic [15:0] STM_CNT_RST  = 16'h0000;

    // Operating modes held in the mode select field.
    typedef enum logic [1:0] {
        STM_MODE_CMP = 2'b00,
        STM_MODE_CAP = 2'b01,
        STM_MODE_PWM = 2'b10,
        STM_MODE_TMR = 2'b11
    } stm_mode_t;

endpackage

/* tb/stm_timer_monitor.sv */
// Port-level checker for the standard timer.
// Assumes it is bound to stm_timer and sees only that module's ports.
`timescale 1ns/1ps
module stm_timer_monitor
    import stm_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and flags
    input wire logic        timer_tick,
    input wire logic        external_trigger_pin,
    input wire logic        timer_out,
    input wire logic        timer_out_en,
    input wire logic        match_a_flag,
    input wire logic        match_p_flag
);
    // ************************************************************
    // Control shadow and assertions
    // ************************************************************
    logic [9:0] sh_reg;
    logic [9:0] sd_reg;
    logic       same;
    logic       sp;
    // Mode bits change only by software, so a shadow of CTRL writes is exact.
    // The delayed copy lets a config settle before the registered pin follows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_reg <= 10'h000;
            sd_reg <= 10'h000;
        end else begin
            if (psel && penable && pwrite && ce && paddr == STM_CTRL_OFS) begin
                sh_reg <= pwdata[9:0];
            end
            sd_reg <= sh_reg;
        end
    end
    assign same = sh_reg == sd_reg;
    assign sp   = same && sh_reg[7:4] == 4'hb;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ready_in_access_a: assert property (psel && penable && ce |-> pready)
        else $error("pready missing in access phase");
    err_needs_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    pin_idle_a: assert property (same && sh_reg[6] |-> !timer_out_en)
        else $error("pin driven in timer or capture mode");
    pwm_forced_a: assert property (same && sh_reg[7:5] == 3'h4 |-> timer_out == sh_reg[4])
        else $error("forced pwm pin level wrong");
    flag_w1c_a: assert property ($fell(match_a_flag) |->
        $past(psel && penable && pwrite && ce && paddr == STM_FLAG_OFS && pwdata[0]))
        else $error("match a flag cleared without write");
    p_on_tick_a: assert property ($rose(match_p_flag) |-> $past(timer_tick && ce))
        else $error("match p flag set without a tick");
    cclr_no_p_a: assert property (same && sh_reg[7:6] == 2'b00 && sh_reg[0] |->
        !$rose(match_p_flag))
        else $error("match p flag set with clear on a");
    pulse_trail_a: assert property (sp && $rose(match_a_flag) |->
        ##[0:2] timer_out != (sh_reg[3] ^ sh_reg[2]))
        else $error("pulse not ended by a match");
    pulse_lead_a: assert property (sp && !sh_reg[9] && $rose(external_trigger_pin) |->
        ##[1:4] timer_out == (sh_reg[3] ^ sh_reg[2]))
        else $error("trigger gave no pulse");

    cover property (sp && $rose(match_a_flag));
    cover property (pslverr);
    cover property ($rose(match_p_flag));
endmodule

bind stm_timer stm_timer_monitor i_mon (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .timer_tick, .external_trigger_pin, .timer_out,
    .timer_out_en, .match_a_flag, .match_p_flag);

/* tb/stm_pins_model.sv */
// Pin-side model: timer clock ticks, trigger and capture input levels.
// Assumes its tasks are called right after a rising edge of pclk.
`timescale 1ns/1ps
module stm_pins_model (
    // Clock
    input wire logic pclk,
    // Pins toward the timer
    output logic     timer_tick,
    output logic     external_trigger_pin,
    output logic     capture_input_pin
);
    // ************************************************************
    // Pin drivers
    // ************************************************************
    // Both inputs are plain driven levels, so they idle low.
    initial begin
        timer_tick = 1'b0;
        external_trigger_pin = 1'b0;
        capture_input_pin = 1'b0;
    end
    // Emits exactly n ticks; slow puts an idle cycle after each one.
    task automatic burst(input int n, input bit slow);
        repeat (n) begin
            @(posedge pclk);
            timer_tick <= 1'b1;
            if (slow) begin
                @(posedge pclk);
                timer_tick <= 1'b0;
            end
        end
        @(posedge pclk);
        timer_tick <= 1'b0;
    endtask
    // Moves the trigger or the capture pin to a new level.
    task automatic drive(input bit trig, input logic lvl);
        @(posedge pclk);
        if (trig) begin
            external_trigger_pin <= lvl;
        end else begin
            capture_input_pin <= lvl;
        end
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the standard timer, in blocks by mode; timer mode shares the clear on A block.
// Assumes the pin model drives the pins and the checker is bound in.
`timescale 1ns/1ps
module tb_top;
    import stm_pkg::*;
    // ************************************************************
    // Signals, design and model
    // ************************************************************
    logic        pclk = 1'b0;
    logic        ce = 1'b1;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, timer_tick, external_trigger_pin;
    logic        capture_input_pin, timer_out, timer_out_en, match_a_flag, match_p_flag;
    int          num_errors = 0;
    int          n_compared = 0;
    localparam logic [7:0] CT = STM_CTRL_OFS;
    localparam logic [7:0] CA = STM_CMPA_OFS;
    localparam logic [7:0] CP = STM_PERD_OFS;
    localparam logic [7:0] CN = STM_CNT_OFS;
    localparam logic [7:0] FL = STM_FLAG_OFS;

    always #2 pclk = ~pclk;
    stm_timer i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .timer_tick, .external_trigger_pin, .capture_input_pin,
        .timer_out, .timer_out_en, .match_a_flag, .match_p_flag);
    stm_pins_model i_pins (.pclk, .timer_tick, .external_trigger_pin, .capture_input_pin);

    // ************************************************************
    // Tasks
    // ************************************************************
    // One APB transfer; an idle edge first keeps drivers from double assignment.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    // The pin is registered, so two edges pass before it is looked at.
    task automatic pin(input logic e);
        repeat (2) @(posedge pclk);
        chk("timer_out", {31'h0, e}, {31'h0, timer_out});
    endtask
    task automatic restart(input logic [31:0] c);
        apb(1'b1, CT, 32'h0);
        apb(1'b1, FL, 32'h3);
        apb(1'b1, CT, c);
    endtask
    task automatic end_of_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ************************************************************
    // Watchdog and main sequence
    // ************************************************************
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 20; a += 4) rdc(a[7:0], 32'h0);
        rdc(8'h14, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        // Compare mode: counting, holding, then matches with clear on P.
        apb(1'b1, CT, 32'h100);
        i_pins.burst(37, 1'b1);
        rdc(CN, 32'd37);
        // A low clock enable must freeze the count under live ticks.
        ce <= 1'b0;
        i_pins.burst(5, 1'b0);
        ce <= 1'b1;
        rdc(CN, 32'd37);
        apb(1'b1, CT, 32'h0);
        i_pins.burst(5, 1'b0);
        rdc(CN, 32'd37);
        apb(1'b1, CP, 32'h1);
        apb(1'b1, CA, 32'h40);
        restart(32'h120);
        i_pins.burst(256, 1'b0);
        rdc(FL, 32'h3);
        rdc(CN, 32'h0);
        pin(1'b1);
        // Clear on A with every pin action, initial level high.
        for (int i = 0; i < 4; i++) begin
            restart(32'h109 | (i << 4));
            i_pins.burst(192, 1'b0);
            pin(!i[0]);
            rdc(FL, 32'h1);
            rdc(CN, 32'h0);
        end
        restart(32'h1c1);
        i_pins.burst(64, 1'b0);
        chk("timer_out_en", 32'h0, {31'h0, timer_out_en});
        rdc(FL, 32'h1);
        // PWM with the period on P, then invert, forcing, full duty and swap.
        restart(32'h1a8);
        i_pins.burst(10, 1'b0);
        pin(1'b1);
        i_pins.burst(60, 1'b0);
        pin(1'b0);
        i_pins.burst(186, 1'b0);
        rdc(CN, 32'h0);
        rdc(FL, 32'h3);
        apb(1'b1, CT, 32'h1ac);
        i_pins.burst(10, 1'b0);
        pin(1'b0);
        apb(1'b1, CT, 32'h19c);
        i_pins.burst(5, 1'b0);
        pin(1'b1);
        rdc(CN, 32'd15);
        apb(1'b1, CA, 32'h100);
        restart(32'h1a8);
        i_pins.burst(256, 1'b0);
        pin(1'b1);
        apb(1'b1, CA, 32'd300);
        restart(32'h1aa);
        i_pins.burst(100, 1'b0);
        pin(1'b1);
        i_pins.burst(180, 1'b0);
        pin(1'b0);
        i_pins.burst(20, 1'b0);
        rdc(CN, 32'h0);
        // Single pulse from the trigger pin, ended by A and by software.
        apb(1'b1, CA, 32'h20);
        restart(32'h0b8);
        i_pins.drive(1'b1, 1'b1);
        repeat (3) @(posedge pclk);
        i_pins.burst(10, 1'b0);
        pin(1'b1);
        i_pins.burst(30, 1'b0);
        pin(1'b0);
        rdc(CT, 32'h0b8);
        rdc(FL, 32'h1);
        i_pins.drive(1'b1, 1'b0);
        i_pins.drive(1'b1, 1'b1);
        repeat (3) @(posedge pclk);
        i_pins.burst(5, 1'b0);
        rdc(CN, 32'd5);
        apb(1'b1, CT, 32'h0b8);
        pin(1'b0);
        // Capture on rising, falling, both, then none.
        apb(1'b1, CP, 32'h0);
        restart(32'h140);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, FL, 32'h3);
            apb(1'b1, CT, 32'h140 | (i << 4));
            i_pins.burst(10, 1'b0);
            i_pins.drive(1'b0, !i[0]);
            repeat (3) @(posedge pclk);
            rdc(CA, i < 3 ? 10 * (i + 1) : 30);
            rdc(FL, {31'h0, i < 3});
        end
        rdc(CN, 32'd40);
        // A period match in capture mode zeroes the counter and sets the P flag.
        apb(1'b1, CP, 32'h1);
        i_pins.burst(216, 1'b0);
        rdc(CN, 32'h0);
        rdc(FL, 32'h2);
        end_of_test();
    end
endmodule
